//--- design/hbcl_bridge_control.v
// brushed motor h-bridge control: decode, chopping, protection, sleep
// Operation
// - both inputs low: coast, sleep after 1 ms
// - single input selects forward or reverse drive
// - both inputs high: brake on low sides
// - dead interval between high and low drive
// - deglitch direction inputs before use
// - trip flagged at ten times sense equals reference
// - trip forces both low sides for off time
// - after off time, return to input state
// - persistent overcurrent enters fault, all switches off
// - overcurrent fault latched until sleep or power cycle
// - any switch overcurrent detector raises fault
// - sense pin overcurrent threshold raises fault too
// - over-temperature disables bridge, resumes automatically
// - undervoltage disables outputs, resets all logic
// - active needs supply good, input high, wake elapsed
// - inputs low for sleep time enters sleep
// - power-up with inputs low goes straight to sleep
// - input held high beyond wake time wakes device
// - chopping off time is 25 us
// - trip comparator ignored 2 us after resuming
// - overcurrent must persist 1.5 us before fault
// - wake time at most 250 us
`timescale 1ns/10ps
`default_nettype none
`include "hbcl_defs.vh"
module hbcl_bridge_control #(
   parameter [23:0] SLEEP_CYC = `HBCL_SLEEP_CYC,
   parameter [23:0] WAKE_CYC  = `HBCL_WAKE_CYC,
   parameter [23:0] OFF_CYC   = `HBCL_OFF_CYC
) (
   input  wire       clock,
   input  wire       arst_n,
   input  wire       dir_input_a,
   input  wire       dir_input_b,
   input  wire       current_trip,
   input  wire [3:0] switch_overcurrent,
   input  wire       sense_pin_overcurrent,
   input  wire       over_temperature,
   input  wire       supply_low_lockout,
   output reg        high_a_on,
   output reg        low_a_on,
   output reg        high_b_on,
   output reg        low_b_on,
   output reg        overcurrent_fault,
   output reg        thermal_fault,
   output reg        active_mode,
   output reg        sleep_mode,
   output reg        chopping
);
   localparam [3:0] ST_START  = 4'h1;
   localparam [3:0] ST_SLEEP  = 4'h2;
   localparam [3:0] ST_WAKE   = 4'h4;
   localparam [3:0] ST_ACTIVE = 4'h8;

   // undervoltage acts as a reset: synchronous clear of all state
   wire lockout;
   assign lockout = supply_low_lockout;

   // input deglitch
   reg [4:0] glitch_cnt;
   reg [1:0] raw_prev;
   reg [1:0] dir;
   wire [1:0] raw_in;
   assign raw_in = {dir_input_b, dir_input_a};

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         raw_prev   <= 2'h0;
         glitch_cnt <= 5'h0;
         dir        <= 2'h0;
      end else if (lockout) begin
         raw_prev   <= 2'h0;
         glitch_cnt <= 5'h0;
         dir        <= 2'h0;
      end else begin
         raw_prev <= raw_in;
         if (raw_in != raw_prev)
            glitch_cnt <= 5'h0;
         else if (glitch_cnt < `HBCL_DEGLITCH_CYC - 1)
            glitch_cnt <= glitch_cnt + 5'h1;
         else
            dir <= raw_in;
      end
   end

   wire both_low;
   assign both_low = (dir == 2'h0);

   // mode machine
   reg  [3:0]  state;
   reg  [23:0] mode_cnt;
   reg         ran_once;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state    <= ST_START;
         mode_cnt <= 24'h0;
         ran_once <= 1'b0;
      end else if (lockout) begin
         state    <= ST_START;
         mode_cnt <= 24'h0;
         ran_once <= 1'b0;
      end else begin
         case (state)
            ST_START: begin
               // wait for deglitched inputs to settle once
               if (glitch_cnt == `HBCL_DEGLITCH_CYC - 1) begin
                  ran_once <= 1'b1;
                  mode_cnt <= 24'h0;
                  // raw level, stable for the full deglitch, is what dir takes now
                  state    <= (raw_in == 2'h0) ? ST_SLEEP : ST_WAKE;
               end
            end
            ST_SLEEP: begin
               mode_cnt <= 24'h0;
               if (!both_low)
                  state <= ST_WAKE;
            end
            ST_WAKE: begin
               if (both_low) begin
                  state    <= ST_SLEEP;
                  mode_cnt <= 24'h0;
               end else if (mode_cnt >= WAKE_CYC - 24'h1) begin
                  state    <= ST_ACTIVE;
                  mode_cnt <= 24'h0;
               end else
                  mode_cnt <= mode_cnt + 24'h1;
            end
            ST_ACTIVE: begin
               if (!both_low)
                  mode_cnt <= 24'h0;
               else if (mode_cnt >= SLEEP_CYC - 24'h1) begin
                  state    <= ST_SLEEP;
                  mode_cnt <= 24'h0;
               end else
                  mode_cnt <= mode_cnt + 24'h1;
            end
            default: begin
               state    <= ST_START;
               mode_cnt <= 24'h0;
            end
         endcase
      end
   end

   wire in_active;
   assign in_active = (state == ST_ACTIVE);

   // overcurrent deglitch and latch
   reg  [6:0] ocp_cnt;
   reg        ocp_latch;
   wire       ocp_raw;
   assign ocp_raw = (|switch_overcurrent) | sense_pin_overcurrent;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ocp_cnt   <= 7'h0;
         ocp_latch <= 1'b0;
      end else if (lockout) begin
         ocp_cnt   <= 7'h0;
         ocp_latch <= 1'b0;
      end else begin
         if (ocp_raw && in_active && ocp_cnt < `HBCL_OCP_CYC)
            ocp_cnt <= ocp_cnt + 7'h1;
         else if (!ocp_raw)
            ocp_cnt <= 7'h0;
         // set wins over the sleep clear
         if (ocp_raw && in_active && ocp_cnt >= `HBCL_OCP_CYC - 1)
            ocp_latch <= 1'b1;
         else if (state == ST_SLEEP)
            ocp_latch <= 1'b0;
      end
   end

   // current chopping: off time then blanking
   reg [10:0] off_cnt;
   reg [6:0]  blank_cnt;
   reg        off_phase;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         off_cnt   <= 11'h0;
         blank_cnt <= 7'h0;
         off_phase <= 1'b0;
      end else if (lockout || !in_active) begin
         off_cnt   <= 11'h0;
         blank_cnt <= 7'h0;
         off_phase <= 1'b0;
      end else if (off_phase) begin
         if (off_cnt >= OFF_CYC[10:0] - 11'h1) begin
            off_phase <= 1'b0;
            off_cnt   <= 11'h0;
            blank_cnt <= 7'h0;
         end else
            off_cnt <= off_cnt + 11'h1;
      end else if (blank_cnt < `HBCL_BLANK_CYC) begin
         blank_cnt <= blank_cnt + 7'h1;
      end else if (current_trip) begin
         off_phase <= 1'b1;
         off_cnt   <= 11'h0;
      end
   end

   // bridge decode
   reg  [1:0] want_a;
   reg  [1:0] want_b;
   wire       drive_ok;
   assign drive_ok = in_active & ~ocp_latch & ~over_temperature;

   always @* begin
      want_a = `HBCL_HB_OFF;
      want_b = `HBCL_HB_OFF;
      if (drive_ok) begin
         if (off_phase) begin
            want_a = `HBCL_HB_LOW;
            want_b = `HBCL_HB_LOW;
         end else begin
            case (dir)
               2'h1: begin
                  want_a = `HBCL_HB_HIGH;
                  want_b = `HBCL_HB_LOW;
               end
               2'h2: begin
                  want_a = `HBCL_HB_LOW;
                  want_b = `HBCL_HB_HIGH;
               end
               2'h3: begin
                  want_a = `HBCL_HB_LOW;
                  want_b = `HBCL_HB_LOW;
               end
               default: begin
                  want_a = `HBCL_HB_OFF;
                  want_b = `HBCL_HB_OFF;
               end
            endcase
         end
      end
   end

   wire ha;
   wire la;
   wire hb;
   wire lb;

   hbcl_half_bridge u_half_a (
      .clock   (clock),
      .arst_n  (arst_n),
      .want    (lockout ? `HBCL_HB_OFF : want_a),
      .high_on (ha),
      .low_on  (la)
   );

   hbcl_half_bridge u_half_b (
      .clock   (clock),
      .arst_n  (arst_n),
      .want    (lockout ? `HBCL_HB_OFF : want_b),
      .high_on (hb),
      .low_on  (lb)
   );

   // registered outputs, forced off at once on fault or lockout
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         high_a_on         <= 1'b0;
         low_a_on          <= 1'b0;
         high_b_on         <= 1'b0;
         low_b_on          <= 1'b0;
         overcurrent_fault <= 1'b0;
         thermal_fault     <= 1'b0;
         active_mode       <= 1'b0;
         sleep_mode        <= 1'b0;
         chopping          <= 1'b0;
      end else begin
         high_a_on         <= ha & drive_ok & ~lockout;
         low_a_on          <= la & drive_ok & ~lockout;
         high_b_on         <= hb & drive_ok & ~lockout;
         low_b_on          <= lb & drive_ok & ~lockout;
         overcurrent_fault <= ocp_latch & ~lockout;
         thermal_fault     <= over_temperature & ~lockout;
         active_mode       <= in_active & ~lockout;
         sleep_mode        <= (state == ST_SLEEP) & ~lockout;
         chopping          <= off_phase & ~lockout;
      end
   end
endmodule // hbcl_bridge_control
`default_nettype wire

//--- design/hbcl_defs.vh
// timing and encoding constants for the h-bridge control logic
`ifndef HBCL_DEFS_VH
`define HBCL_DEFS_VH
`define HBCL_CLK_MHZ           50
// times in ns, as printed
`define HBCL_DEAD_NS           200
`define HBCL_DEGLITCH_NS       400
`define HBCL_OFF_NS            25000
`define HBCL_BLANK_NS          2000
`define HBCL_OCP_NS            1500
`define HBCL_WAKE_NS           250000
`define HBCL_SLEEP_NS          1000000
// cycle counts: least times round up, longest times round down
`define HBCL_DEAD_CYC          ((`HBCL_DEAD_NS * `HBCL_CLK_MHZ + 999) / 1000)
`define HBCL_DEGLITCH_CYC      ((`HBCL_DEGLITCH_NS * `HBCL_CLK_MHZ + 999) / 1000)
`define HBCL_OFF_CYC           ((`HBCL_OFF_NS * `HBCL_CLK_MHZ + 999) / 1000)
`define HBCL_BLANK_CYC         ((`HBCL_BLANK_NS * `HBCL_CLK_MHZ + 999) / 1000)
`define HBCL_OCP_CYC           ((`HBCL_OCP_NS * `HBCL_CLK_MHZ + 999) / 1000)
`define HBCL_WAKE_CYC          ((`HBCL_WAKE_NS * `HBCL_CLK_MHZ) / 1000)
`define HBCL_SLEEP_CYC         ((`HBCL_SLEEP_NS * `HBCL_CLK_MHZ) / 1000)
// half-bridge drive codes {high_on, low_on}
`define HBCL_HB_OFF            2'h0
`define HBCL_HB_LOW            2'h1
`define HBCL_HB_HIGH           2'h2
`endif

//--- design/hbcl_half_bridge.v
// one half bridge with dead interval between high and low drive
`timescale 1ns/10ps
`default_nettype none
`include "hbcl_defs.vh"
module hbcl_half_bridge (
   input  wire       clock,
   input  wire       arst_n,
   input  wire [1:0] want,
   output reg        high_on,
   output reg        low_on
);
   reg  [3:0] dead_cnt;
   reg  [1:0] cur;
   wire [1:0] next_cur;

   assign next_cur = {high_on, low_on};

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dead_cnt <= 4'h0;
         high_on  <= 1'b0;
         low_on   <= 1'b0;
         cur      <= `HBCL_HB_OFF;
      end else if (want == `HBCL_HB_OFF) begin
         high_on  <= 1'b0;
         low_on   <= 1'b0;
         dead_cnt <= 4'h0;
         cur      <= `HBCL_HB_OFF;
      end else if (want != next_cur) begin
         // both switches off before the opposite one turns on
         high_on <= 1'b0;
         low_on  <= 1'b0;
         if (next_cur != `HBCL_HB_OFF || (cur != `HBCL_HB_OFF && cur != want &&
             dead_cnt < `HBCL_DEAD_CYC - 1)) begin
            if (next_cur != `HBCL_HB_OFF)
               cur <= next_cur;
            dead_cnt <= (next_cur != `HBCL_HB_OFF) ? 4'h0 : dead_cnt + 4'h1;
         end else begin
            high_on  <= want[1];
            low_on   <= want[0];
            cur      <= want;
            dead_cnt <= 4'h0;
         end
      end
   end
endmodule // hbcl_half_bridge
`default_nettype wire

//--- sim/hbcl_monitor.sv
// concurrent checks on the h-bridge control logic ports
`timescale 1ns/10ps
`default_nettype none
module hbcl_monitor #(
   parameter [23:0] SLEEP_CYC = 24'h00_c350,
   parameter [23:0] WAKE_CYC  = 24'h00_30d4,
   parameter [23:0] OFF_CYC   = 24'h00_04e2
) (
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic       dir_input_a,
   input wire logic       dir_input_b,
   input wire logic       current_trip,
   input wire logic [3:0] switch_overcurrent,
   input wire logic       sense_pin_overcurrent,
   input wire logic       over_temperature,
   input wire logic       supply_low_lockout,
   input wire logic       high_a_on,
   input wire logic       low_a_on,
   input wire logic       high_b_on,
   input wire logic       low_b_on,
   input wire logic       overcurrent_fault,
   input wire logic       thermal_fault,
   input wire logic       active_mode,
   input wire logic       sleep_mode,
   input wire logic       chopping
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire       off4 = !(high_a_on | low_a_on | high_b_on | low_b_on);
   wire       oc_any = (|switch_overcurrent) | sense_pin_overcurrent;
   reg [23:0] chop_cnt;
   // cycles spent in the current off phase
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) chop_cnt <= 24'h00_0000;
      else chop_cnt <= chopping ? chop_cnt + 24'h00_0001 : 24'h00_0000;
   end
   sequence oc_held;
      $past(oc_any, 1) && $past(oc_any, 8);
   endsequence
   sequence chop_end;
      $fell(chopping) && !overcurrent_fault && !thermal_fault && !$past(supply_low_lockout);
   endsequence
   half_a_dead_a: assert property ($fell(high_a_on) |-> !low_a_on [*8])
      else $error("low side a on inside dead interval");
   half_b_dead_a: assert property ($fell(low_b_on) |-> !high_b_on [*8])
      else $error("high side b on inside dead interval");
   overcur_off_a: assert property (overcurrent_fault [*3] |-> off4)
      else $error("switch on during overcurrent fault");
   overcur_latch_a: assert property ($fell(overcurrent_fault) |-> sleep_mode || $past(sleep_mode))
      else $error("overcurrent fault cleared without sleep");
   overcur_deglitch_a: assert property ($rose(overcurrent_fault) |-> oc_held)
      else $error("overcurrent fault without persistent detector");
   thermal_off_a: assert property (thermal_fault [*3] |-> off4)
      else $error("switch on during thermal fault");
   supply_low_a: assert property ($past(supply_low_lockout) |-> off4 && !active_mode && !overcurrent_fault)
      else $error("outputs alive under supply lockout");
   sleep_off_a: assert property (sleep_mode |-> off4 && !active_mode)
      else $error("bridge driven while asleep");
   wake_gate_a: assert property ($rose(active_mode) |-> $past(dir_input_a | dir_input_b))
      else $error("active without an input high");
   chop_low_a: assert property (chopping [*4] |-> !high_a_on && !high_b_on)
      else $error("high side on during off time");
   chop_length_a: assert property (chop_end |-> chop_cnt >= OFF_CYC)
      else $error("off time ended early");
endmodule // hbcl_monitor
bind hbcl_bridge_control hbcl_monitor #(.SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC), .OFF_CYC(OFF_CYC)) i_mon (.*);
`default_nettype wire

//--- sim/hbcl_ctrl_model.sv
// controller model driving the two direction inputs
`timescale 1ns/10ps
`default_nettype none
module hbcl_ctrl_model (
   input  wire logic       clock,
   input  wire logic [1:0] cmd,
   output var  logic       dir_input_a,
   output var  logic       dir_input_b
);
   initial {dir_input_a, dir_input_b} = 2'h0;
   // levels move only on falling edges and are held as commanded
   always @(negedge clock) begin
      dir_input_a <= cmd[1];
      dir_input_b <= cmd[0];
   end
endmodule // hbcl_ctrl_model
`default_nettype wire

//--- sim/tb_hbridge_control_logic.sv
// self-checking bench for the h-bridge control logic
`timescale 1ns/10ps
`default_nettype none
module tb_hbridge_control_logic;
   logic       clock = 1'b0;
   logic       arst_n = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic       current_trip = 1'b0;
   logic [3:0] switch_overcurrent = 4'h0;
   logic       sense_pin_overcurrent = 1'b0;
   logic       over_temperature = 1'b0;
   logic       supply_low_lockout = 1'b0;
   wire        dir_a, dir_b, ha, la, hb, lb, flt, tflt, act, slp, chop;
   wire [3:0]  sw = {ha, la, hb, lb};
   int         n_mismatch = 0;
   int         cmp_count = 0;
   always #10 clock = ~clock;
   hbcl_ctrl_model i_ctl (.clock(clock), .cmd(cmd), .dir_input_a(dir_a), .dir_input_b(dir_b));
   hbcl_bridge_control #(.SLEEP_CYC(24'h00_00c8), .WAKE_CYC(24'h00_0032), .OFF_CYC(24'h00_0028)) i_dut (
      .clock(clock), .arst_n(arst_n), .dir_input_a(dir_a), .dir_input_b(dir_b),
      .current_trip(current_trip), .switch_overcurrent(switch_overcurrent),
      .sense_pin_overcurrent(sense_pin_overcurrent), .over_temperature(over_temperature),
      .supply_low_lockout(supply_low_lockout), .high_a_on(ha), .low_a_on(la), .high_b_on(hb),
      .low_b_on(lb), .overcurrent_fault(flt), .thermal_fault(tflt), .active_mode(act),
      .sleep_mode(slp), .chopping(chop));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // sel: 0 active, 1 sleep, 2 fault, 3 chopping
   task automatic wait_for(input int sel, input logic lvl, input int bound, output int n);
      for (n = 0; n < bound; n++) begin
         @(negedge clock);
         if ((sel == 0 ? act : sel == 1 ? slp : sel == 2 ? flt : chop) === lvl) return;
      end
      n_mismatch++;
      $display("wrong value at %0t: wait ran out", $time);
      report_and_stop;
   endtask
   task automatic go(input logic [1:0] c, input int k);
      @(negedge clock);
      cmd <= c;
      repeat (k) @(negedge clock);
   endtask
   task automatic wake_fwd;
      int n;
      go(2'h2, 0);
      wait_for(0, 1'b1, 200, n);
      check(8'(n >= 50), 8'h01);
      repeat (20) @(negedge clock);
      check({4'h0, sw}, 8'h09);
   endtask
   task automatic t_directions;
      logic [1:0] c [3] = '{2'h1, 2'h3, 2'h2};
      logic [3:0] e [3] = '{4'h6, 4'h5, 4'h9};
      go(2'h1, 5);
      go(2'h2, 40);
      check({4'h0, sw}, 8'h09);
      for (int i = 0; i < 3; i++) begin
         go(c[i], 40);
         check({4'h0, sw}, {4'h0, e[i]});
      end
   endtask
   task automatic t_coast;
      int n;
      go(2'h0, 100);
      check({3'h0, slp, sw}, 8'h00);
      wait_for(1, 1'b1, 200, n);
      check(8'(n >= 90), 8'h01);
      wake_fwd();
   endtask
   task automatic t_chop;
      int n;
      repeat (100) @(negedge clock);
      current_trip <= 1'b1;
      wait_for(3, 1'b1, 5, n);
      repeat (15) @(negedge clock);
      check({4'h0, sw}, 8'h05);
      current_trip <= 1'b0;
      wait_for(3, 1'b0, 100, n);
      check(8'(n >= 24), 8'h01);
      repeat (20) @(negedge clock);
      check({4'h0, sw}, 8'h09);
      current_trip <= 1'b1;
      repeat (30) @(negedge clock);
      check({7'h00, chop}, 8'h00);
      current_trip <= 1'b0;
   endtask
   task automatic t_overcurrent;
      int n;
      switch_overcurrent <= 4'h1;
      repeat (30) @(negedge clock);
      switch_overcurrent <= 4'h0;
      repeat (100) @(negedge clock);
      check({7'h00, flt}, 8'h00);
      for (int i = 0; i < 5; i++) begin
         if (i < 4) switch_overcurrent <= 4'h1 << i;
         else sense_pin_overcurrent <= 1'b1;
         wait_for(2, 1'b1, 100, n);
         check(8'(n >= 70), 8'h01);
         repeat (3) @(negedge clock);
         check({4'h0, sw}, 8'h00);
         switch_overcurrent <= 4'h0;
         sense_pin_overcurrent <= 1'b0;
         repeat (20) @(negedge clock);
         check({7'h00, flt}, 8'h01);
         go(2'h0, 0);
         wait_for(1, 1'b1, 300, n);
         repeat (2) @(negedge clock);
         check({7'h00, flt}, 8'h00);
         wake_fwd();
      end
   endtask
   task automatic t_thermal_supply;
      int n;
      over_temperature <= 1'b1;
      repeat (5) @(negedge clock);
      check({3'h0, tflt, sw}, 8'h10);
      over_temperature <= 1'b0;
      repeat (20) @(negedge clock);
      check({3'h0, tflt, sw}, 8'h09);
      supply_low_lockout <= 1'b1;
      repeat (3) @(negedge clock);
      check({act, slp, flt, tflt, sw}, 8'h00);
      supply_low_lockout <= 1'b0;
      wait_for(0, 1'b1, 200, n);
      check(8'(n >= 50), 8'h01);
   endtask
   initial begin
      int n;
      repeat (12) @(negedge clock);
      arst_n <= 1'b1;
      wait_for(1, 1'b1, 60, n);
      check({3'h0, act, sw}, 8'h00);
      wake_fwd();
      t_directions();
      t_coast();
      t_chop();
      t_overcurrent();
      t_thermal_supply();
      report_and_stop();
   end
endmodule // tb_hbridge_control_logic
`default_nettype wire
